/* File: ifp_top.sv */
// instruction fetch pipeline with whole-instruction buffer
`timescale 1ns/100ps
`default_nettype none
`include "ifp_consts.svh"
module ifp_top import ifp_pkg::*; #(
  parameter int CLK_RATIO = `IFP_CLK_RATIO
) (
  input wire logic core_clk, // 250 MHz core clock
  input wire logic rstn, // sync reset, low
  output var ifp_mreq_t mem_out, // fetch request
  input wire logic [31:0] mem_rdata, // data in second cycle
  input wire logic ccr_fwd_taken, // forward-taken control bit
  input wire logic ex_done, // execution completed one
  input wire logic ex_flush, // execution redirect
  input wire logic [31:0] ex_target, // its target
  output logic ex_valid, // instruction presented
  output var ifp_entry_t ex_entry, // the instruction
  output logic sys_tick // slow clock phase strobe
);
  //////////////////////////////////////////////////////////////
  // early decode of one opcode
  function automatic ifp_dec_t ifp_decode(input logic [15:0] op);
    ifp_dec_t d;
    d = '0;
    if (op[15:12] == `IFP_OP_BCC) begin
      d.cof = 1'b1;
      if (op[7:0] == `IFP_D8_W16) d.ext_cnt = 2'h1;
      else if (op[7:0] == `IFP_D8_L32) d.ext_cnt = 2'h2;
    end else if (op == `IFP_OP_JMPABS) begin
      d.cof = 1'b1;
      d.ext_cnt = 2'h2;
    end else begin
      // length from the addressing mode field
      if (op[5:3] == `IFP_EA_ABS) d.ext_cnt = op[0] ? 2'h2 : 2'h1;
      // moves store, so they keep single-cycle timing
      d.mem_rd = op[5:3] >= `IFP_EA_MEM && op[15:12] != 4'h0
        && op[15:14] != 2'h0;
    end
    return d;
  endfunction : ifp_decode

  //////////////////////////////////////////////////////////////
  // state
  logic [31:0] fa_reg; // address gen stage
  logic [31:0] ic1_pc_reg;
  logic [31:0] ic2_pc_reg;
  logic ic1_v_reg;
  logic ic2_v_reg;
  logic [15:0] hw_reg [`IFP_HWQ];
  logic [3:0] hq_cnt_reg;
  logic [31:0] hq_pc_reg;
  ifp_entry_t iq_reg [`IFP_QDEPTH];
  logic [2:0] iq_rd_reg;
  logic [2:0] iq_wr_reg;
  logic [3:0] iq_cnt_reg;
  logic ccr_fwd_reg;
  logic [7:0] tick_cnt_reg;
  logic ex_v_reg;
  ifp_entry_t ex_reg;
  logic tick_reg;

  //////////////////////////////////////////////////////////////
  // early decode stage: head of the halfword aligner
  wire [15:0] ied_op = hw_reg[0];
  ifp_dec_t ied_dec_raw;
  assign ied_dec_raw = ifp_decode(ied_op);
  wire [3:0] ied_len = {2'h0, ied_dec_raw.ext_cnt} + 4'h1;
  wire ied_whole = hq_cnt_reg >= ied_len && hq_cnt_reg != 4'h0;
  wire [31:0] ied_seq = hq_pc_reg + `IFP_PC_STEP;
  wire [31:0] d8_ext = {{24{ied_op[7]}}, ied_op[7:0]};
  wire [31:0] d16_ext = {{16{hw_reg[1][15]}}, hw_reg[1]};
  wire [31:0] d32 = {hw_reg[1], hw_reg[2]};
  wire is_jmp = ied_op == `IFP_OP_JMPABS;
  wire [31:0] bcc_disp = ied_dec_raw.ext_cnt == 2'h0 ? d8_ext :
    ied_dec_raw.ext_cnt == 2'h1 ? d16_ext : d32;
  wire [31:0] ied_tgt = is_jmp ? d32 : ied_seq + bcc_disp;
  wire ied_cond = !is_jmp && ied_op[11:8] != `IFP_CC_BRA
    && ied_op[11:8] != `IFP_CC_BSR;
  // backward means below the branch's own address; equal counts as forward
  wire ied_back = ied_tgt < hq_pc_reg;
  // static rule only, every branch, no table
  wire ied_pred = !ied_cond || ied_back || ccr_fwd_reg;
  ifp_dec_t ied_dec;
  always_comb begin
    ied_dec = ied_dec_raw;
    ied_dec.pred_taken = ied_dec_raw.cof && ied_pred;
  end
  ifp_entry_t ied_entry;
  assign ied_entry = '{op: ied_op, dec: ied_dec, ext1: hw_reg[1],
    ext2: hw_reg[2], pc: hq_pc_reg};

  //////////////////////////////////////////////////////////////
  // buffer, bypass and execution handoff
  wire ex_free = !ex_v_reg || ex_done;
  wire iq_empty = iq_cnt_reg == 4'h0;
  // bypass only with nothing older waiting, so program order holds
  wire bypass_ok = iq_empty && ex_free;
  wire iq_room = iq_cnt_reg != 4'(`IFP_QDEPTH);
  wire ied_fire = ied_whole && (iq_room || bypass_ok) && !ex_flush;
  wire ied_redir = ied_fire && ied_dec.pred_taken;
  wire iq_pop = ex_free && !iq_empty && !ex_flush;
  wire iq_push = ied_fire && !bypass_ok;
  wire redirect = ex_flush || ied_redir;
  wire [31:0] redir_pc = ex_flush ? ex_target : ied_tgt;

  //////////////////////////////////////////////////////////////
  // aligner next state
  wire [3:0] rm = ied_fire ? ied_len : 4'h0;
  wire ic2_skip = ic2_pc_reg[1];
  wire [15:0] in0 = ic2_skip ? mem_rdata[15:0] : mem_rdata[31:16];
  wire [15:0] in1 = mem_rdata[15:0];
  wire [3:0] in_n = !ic2_v_reg ? 4'h0 : ic2_skip ? 4'h1 : 4'h2;
  wire [3:0] keep = hq_cnt_reg - rm;
  // slots past the count are don't-care; decode never looks at them
  logic [15:0] hw_next [`IFP_HWQ];
  always_comb begin
    int k;
    int j;
    k = 0;
    j = 0;
    for (int i = 0; i < `IFP_HWQ; i++) begin
      k = i + int'(rm);
      j = i - int'(keep);
      hw_next[i] = hw_reg[i];
      if (k < int'(hq_cnt_reg) && k < `IFP_HWQ) hw_next[i] = hw_reg[k];
      else if (j == 0) hw_next[i] = in0;
      else if (j == 1) hw_next[i] = in1;
    end
  end
  wire [3:0] hq_cnt_next = redirect ? 4'h0 : keep + in_n;
  wire [31:0] hq_pc_next = keep == 4'h0 ?
    {ic2_pc_reg[31:2], 2'h0} + (ic2_skip ? `IFP_PC_STEP : 32'h0) :
    hq_pc_reg + {27'h0, rm, 1'b0};
  // in-flight words counted so a fetch never overruns the aligner
  wire [4:0] hq_need = {1'b0, hq_cnt_reg} + 5'h2 +
    {3'h0, ic1_v_reg, 1'b0} + {3'h0, ic2_v_reg, 1'b0};
  wire issue = hq_need <= 5'(`IFP_HWQ) && !redirect;

  //////////////////////////////////////////////////////////////
  // address gen and two memory cycles
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fa_reg <= `IFP_RESET_PC;
      ic1_v_reg <= 1'b0;
      ic2_v_reg <= 1'b0;
      ic1_pc_reg <= `IFP_RESET_PC;
      ic2_pc_reg <= `IFP_RESET_PC;
    end else begin
      if (redirect) fa_reg <= redir_pc;
      else if (issue) fa_reg <= {fa_reg[31:2], 2'h0} + 32'h00000004;
      ic1_v_reg <= issue;
      ic1_pc_reg <= fa_reg;
      ic2_v_reg <= ic1_v_reg && !redirect;
      ic2_pc_reg <= ic1_pc_reg;
    end
  end

  // aligner registers; a redirect drops what follows the branch
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hq_cnt_reg <= 4'h0;
      hq_pc_reg <= `IFP_RESET_PC;
    end else begin
      hq_cnt_reg <= hq_cnt_next;
      hq_pc_reg <= hq_pc_next;
    end
  end
  always_ff @(posedge core_clk) begin
    hw_reg <= hw_next;
  end

  //////////////////////////////////////////////////////////////
  // instruction buffer, whole instructions
  always_ff @(posedge core_clk) begin
    if (iq_push) iq_reg[iq_wr_reg] <= ied_entry;
  end
  always_ff @(posedge core_clk) begin
    if (!rstn || ex_flush) begin
      iq_rd_reg <= 3'h0;
      iq_wr_reg <= 3'h0;
      iq_cnt_reg <= 4'h0;
    end else begin
      iq_rd_reg <= iq_rd_reg + 3'(iq_pop);
      iq_wr_reg <= iq_wr_reg + 3'(iq_push);
      iq_cnt_reg <= iq_cnt_reg + 4'(iq_push) - 4'(iq_pop);
    end
  end

  // execution handoff register
  always_ff @(posedge core_clk) begin
    if (!rstn || ex_flush) begin
      ex_v_reg <= 1'b0;
      ex_reg <= '0;
    end else if (ex_free) begin
      ex_v_reg <= iq_pop || ied_fire;
      ex_reg <= iq_pop ? iq_reg[iq_rd_reg] : ied_entry;
    end
  end

  //////////////////////////////////////////////////////////////
  // boundary: control bit and slow-phase strobe registered
  // a register on each side of the boundary keeps the slow paths short
  wire tick_wrap = tick_cnt_reg == 8'(CLK_RATIO - 1);
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ccr_fwd_reg <= 1'b0;
      tick_cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      ccr_fwd_reg <= ccr_fwd_taken;
      tick_cnt_reg <= tick_wrap ? 8'h00 : tick_cnt_reg + 8'h01;
      tick_reg <= tick_wrap;
    end
  end

  // outputs straight from flops
  assign mem_out = '{req: ic1_v_reg, addr: {ic1_pc_reg[31:2], 2'h0}};
  assign ex_valid = ex_v_reg;
  assign ex_entry = ex_reg;
  assign sys_tick = tick_reg;

  //////////////////////////////////////////////////////////////
  // checks
  ifp_entry_t head_q;
  assign head_q = iq_reg[iq_rd_reg];
  sequence s_issue;
    issue ##1 mem_out.req;
  endsequence
  property p_two_cycle;
    @(posedge core_clk) disable iff (!rstn)
      s_issue ##0 !redirect |=> ic2_v_reg;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("fetch lost");
  property p_redir_fetch;
    @(posedge core_clk) disable iff (!rstn)
      redirect && !ex_flush |=> !ic1_v_reg && !ic2_v_reg
        && hq_cnt_reg == 4'h0 ##1 (mem_out.req || $past(ex_flush));
  endproperty
  a_redir_fetch: assert property (p_redir_fetch) else $error("no refetch");
  property p_redir_addr;
    @(posedge core_clk) disable iff (!rstn)
      redirect |=> fa_reg == $past(redir_pc);
  endproperty
  a_redir_addr: assert property (p_redir_addr) else $error("bad target");
  property p_qmax;
    @(posedge core_clk) disable iff (!rstn)
      iq_cnt_reg <= 4'(`IFP_QDEPTH);
  endproperty
  a_qmax: assert property (p_qmax) else $error("buffer overrun");
  property p_stall;
    @(posedge core_clk) disable iff (!rstn)
      !iq_room && !ex_free |-> !ied_fire;
  endproperty
  a_stall: assert property (p_stall) else $error("full not stalled");
  property p_back;
    @(posedge core_clk) disable iff (!rstn)
      ied_fire && ied_dec.cof && ied_cond && ied_back |-> redirect;
  endproperty
  a_back: assert property (p_back) else $error("back not taken");
  property p_fwd;
    @(posedge core_clk) disable iff (!rstn)
      ied_fire && ied_dec.cof && ied_cond && !ied_back
        |-> ied_redir == ccr_fwd_reg;
  endproperty
  a_fwd: assert property (p_fwd) else $error("fwd predict");
  property p_advance;
    @(posedge core_clk) disable iff (!rstn)
      iq_pop |=> ex_v_reg && ex_reg == $past(head_q);
  endproperty
  a_advance: assert property (p_advance) else $error("no advance");
  property p_bypass;
    @(posedge core_clk) disable iff (!rstn)
      ied_fire && bypass_ok |=> ex_reg.op == $past(ied_op)
        && iq_cnt_reg == 4'h0;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass");
  property p_tick;
    @(posedge core_clk) disable iff (!rstn)
      sys_tick |=> !sys_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("ratio below 2");
  // held plus in-flight halfwords never exceed the aligner slots
  property p_hq_bound;
    @(posedge core_clk) disable iff (!rstn)
      {1'b0, hq_cnt_reg} + {3'h0, ic1_v_reg, 1'b0} + {3'h0, ic2_v_reg, 1'b0}
        <= 5'(`IFP_HWQ);
  endproperty
  a_hq_bound: assert property (p_hq_bound) else $error("aligner overrun");
  // a flush empties everything in one cycle and refetches in the next
  sequence s_flush_clear;
    !ex_valid && iq_cnt_reg == 4'h0 && hq_cnt_reg == 4'h0;
  endsequence
  property p_flush;
    @(posedge core_clk) disable iff (!rstn)
      ex_flush ##1 !ex_flush |-> s_flush_clear
        ##1 mem_out.req && mem_out.addr == {$past(ex_target[31:2], 2), 2'h0};
  endproperty
  a_flush: assert property (p_flush) else $error("flush");
  // an entry stands until execution completes it or flushes
  property p_hold;
    @(posedge core_clk) disable iff (!rstn)
      ex_valid && !ex_done && !ex_flush |=> ex_valid && $stable(ex_entry);
  endproperty
  a_hold: assert property (p_hold) else $error("entry changed");
  // each pop from the buffer moves the read side by exactly one entry
  property p_pop_step;
    @(posedge core_clk) disable iff (!rstn)
      iq_pop |=> iq_rd_reg == $past(iq_rd_reg) + 3'h1;
  endproperty
  a_pop_step: assert property (p_pop_step) else $error("read step");
  // a decoded instruction that cannot bypass takes one more entry
  property p_push_step;
    @(posedge core_clk) disable iff (!rstn)
      iq_push && !iq_pop |=> iq_cnt_reg == $past(iq_cnt_reg) + 4'h1;
  endproperty
  a_push_step: assert property (p_push_step) else $error("push count");
  // back-to-back requests walk up one word at a time
  property p_fetch_step;
    @(posedge core_clk) disable iff (!rstn)
      mem_out.req ##1 mem_out.req |-> mem_out.addr == $past(mem_out.addr) + 32'h00000004;
  endproperty
  a_fetch_step: assert property (p_fetch_step) else $error("fetch step");
endmodule : ifp_top
`default_nettype wire

/* File: ifp_consts.svh */
// constants of the instruction fetch pipeline
`ifndef IFP_CONSTS_SVH
`define IFP_CONSTS_SVH
`define IFP_RESET_PC 32'h00000000
`define IFP_QDEPTH 8
`define IFP_HWQ 8
`define IFP_CLK_RATIO 2
`define IFP_OP_BCC 4'h6
`define IFP_OP_JMPABS 16'h4ef9
`define IFP_D8_W16 8'h00
`define IFP_D8_L32 8'hff
`define IFP_CC_BRA 4'h0
`define IFP_CC_BSR 4'h1
`define IFP_EA_ABS 3'h7
`define IFP_EA_MEM 3'h2
`define IFP_PC_STEP 32'h00000002
`endif

/* File: ifp_pkg.sv */
// types of the instruction fetch pipeline
package ifp_pkg;
  // early decode word, 16 bits
  typedef struct packed {
    logic [1:0] ext_cnt;
    logic cof;
    logic pred_taken;
    logic mem_rd;
    logic [10:0] spare;
  } ifp_dec_t;
  // one whole machine instruction
  typedef struct packed {
    logic [15:0] op;
    ifp_dec_t dec;
    logic [15:0] ext1;
    logic [15:0] ext2;
    logic [31:0] pc;
  } ifp_entry_t;
  // local memory request
  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } ifp_mreq_t;
endpackage : ifp_pkg

/* File: ifp_mem_model.sv */
// local memory model answering each fetch one cycle after its request
`timescale 1ns/100ps
`default_nettype none
module ifp_mem_model import ifp_pkg::*; (
  input wire logic core_clk, // core clock
  input wire ifp_mreq_t mem_out, // fetch request
  output logic [31:0] mem_rdata // data in cycle two
);
  logic [31:0] img [0:255];
  logic [31:0] rdata_reg = 32'h0;
  ////////////////////////////////////////////////////////////////////
  // idle cycles invert the data, so a stale word passes as fresh only after an even number of them
  always_ff @(posedge core_clk) begin
    if (mem_out.req) begin
      rdata_reg <= img[mem_out.addr[9:2]];
    end else begin
      rdata_reg <= ~rdata_reg;
    end
  end
  assign mem_rdata = rdata_reg;
endmodule : ifp_mem_model
`default_nettype wire

/* File: ifp_top_tb.sv */
// self-checking bench of the instruction fetch pipeline
`timescale 1ns/100ps
`default_nettype none
module ifp_top_tb import ifp_pkg::*;;
  localparam int CR = 3;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic ccr_fwd_taken = 1'h0;
  logic ex_done = 1'h0;
  logic ex_flush = 1'h0;
  logic [31:0] ex_target = 32'h0;
  logic [31:0] mem_rdata;
  ifp_mreq_t mem_out;
  logic ex_valid;
  ifp_entry_t ex_entry;
  logic sys_tick;
  logic [15:0] prog[$];
  int fails = 0;
  int n_compared = 0;
  ////////////////////////////////////////////////////////////////////
  ifp_top #(.CLK_RATIO(CR)) u_ifp_top (.core_clk(core_clk), .rstn(rstn),
    .mem_out(mem_out), .mem_rdata(mem_rdata), .ccr_fwd_taken(ccr_fwd_taken),
    .ex_done(ex_done), .ex_flush(ex_flush), .ex_target(ex_target),
    .ex_valid(ex_valid), .ex_entry(ex_entry), .sys_tick(sys_tick));
  ifp_mem_model u_ifp_mem_model (.core_clk(core_clk), .mem_out(mem_out),
    .mem_rdata(mem_rdata));
  // 250 MHz core clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  // load the image, hold reset ten cycles, release
  task automatic restart(input logic fwd);
    for (int i = 0; i < 256; i++) u_ifp_mem_model.img[i] = 32'h70007000;
    foreach (prog[i]) begin
      if (i % 2) u_ifp_mem_model.img[i/2][15:0] = prog[i];
      else u_ifp_mem_model.img[i/2][31:16] = prog[i];
    end
    ccr_fwd_taken = fwd;
    rstn = 1'h0;
    repeat (10) @(negedge core_clk);
    cmp(mem_out.req, 1'h0, "req in reset"); // RESET
    cmp(ex_valid, 1'h0, "valid in reset"); // RESET
    cmp(sys_tick, 1'h0, "tick in reset"); // RESET
    rstn = 1'h1;
  endtask : restart
  // await an instruction, judge it, complete it; 2 means not judged
  task automatic chk(input logic [15:0] op, input logic [31:0] pc, input logic [1:0] cnt,
      input logic [1:0] pr, input logic [1:0] mrd = 2'h2, input logic [15:0] e1 = 16'h0,
      input logic [15:0] e2 = 16'h0);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (ex_valid !== 1'h1 && n < 40);
    cmp(ex_valid, 1'h1, "valid");
    cmp(ex_entry.op, op, "op");
    cmp(ex_entry.pc, pc, "pc");
    cmp(ex_entry.dec.ext_cnt, cnt, "ext count");
    if (pr < 2) cmp(ex_entry.dec.pred_taken, pr, "prediction");
    if (mrd < 2) cmp(ex_entry.dec.mem_rd, mrd, "mem read");
    if (cnt != 0) cmp(ex_entry.ext1, e1, "ext1");
    if (cnt == 2) cmp(ex_entry.ext2, e2, "ext2");
    ex_done = 1'h1;
    @(negedge core_clk);
    ex_done = 1'h0;
  endtask : chk
  ////////////////////////////////////////////////////////////////////
  task automatic t_seq();
    prog = '{16'h3038, 16'h1111, 16'h3039, 16'h2222, 16'h3333, 16'hd010};
    restart(1'h0);
    @(negedge core_clk);
    cmp(mem_out.req, 1'h1, "first req"); // RESET
    cmp(mem_out.addr, 32'h0, "first addr"); // RESET
    repeat (2) @(negedge core_clk);
    cmp(ex_valid, 1'h0, "valid early");
    @(negedge core_clk);
    cmp(ex_valid, 1'h1, "valid on time");
    chk(16'h3038, 32'h0, 2'h1, 2'h2, 2'h0, 16'h1111);
    chk(16'h3039, 32'h4, 2'h2, 2'h2, 2'h0, 16'h2222, 16'h3333);
    chk(16'hd010, 32'ha, 2'h0, 2'h2, 2'h1);
    chk(16'h7000, 32'hc, 2'h0, 2'h0, 2'h0);
  endtask : t_seq
  task automatic t_branch(input logic fwd);
    prog = '{16'h7000, 16'h7000, 16'h7000, 16'h7000, 16'h6608, 16'h6efa};
    restart(fwd);
    for (int a = 0; a < 8; a += 2) chk(16'h7000, a, 2'h0, 2'h0);
    if (fwd) begin
      chk(16'h6608, 32'h8, 2'h0, 2'h1);
      chk(16'h7000, 32'h12, 2'h0, 2'h0);
    end else begin
      chk(16'h6608, 32'h8, 2'h0, 2'h0);
      chk(16'h6efa, 32'ha, 2'h0, 2'h1);
      chk(16'h7000, 32'h6, 2'h0, 2'h0);
      chk(16'h6608, 32'h8, 2'h0, 2'h0);
      chk(16'h6efa, 32'ha, 2'h0, 2'h1);
    end
  endtask : t_branch
  task automatic t_jump();
    prog = '{16'h4ef9, 16'h0000, 16'h0040};
    restart(1'h0);
    chk(16'h4ef9, 32'h0, 2'h2, 2'h1, 2'h0, 16'h0000, 16'h0040);
    chk(16'h7000, 32'h40, 2'h0, 2'h0);
  endtask : t_jump
  task automatic t_flush();
    prog.delete();
    restart(1'h0);
    chk(16'h7000, 32'h0, 2'h0, 2'h0);
    @(negedge core_clk);
    ex_flush = 1'h1;
    ex_target = 32'h100;
    @(negedge core_clk);
    ex_flush = 1'h0;
    cmp(ex_valid, 1'h0, "valid after flush");
    @(negedge core_clk);
    cmp(mem_out.req, 1'h1, "req after flush");
    cmp(mem_out.addr, 32'h100, "flush addr");
    chk(16'h7000, 32'h100, 2'h0, 2'h0);
  endtask : t_flush
  // no completions: fetch must stop, then the first twelve drain in order
  task automatic t_stall();
    int n;
    n = 0;
    prog.delete();
    restart(1'h0);
    repeat (60) @(negedge core_clk);
    repeat (20) begin
      @(negedge core_clk);
      n += mem_out.req;
    end
    cmp(n, 0, "fetch while full");
    for (int a = 0; a < 24; a += 2) chk(16'h7000, a, 2'h0, 2'h0);
  endtask : t_stall
  task automatic t_tick();
    int n;
    n = 0;
    restart(1'h0);
    repeat (30) begin
      @(negedge core_clk);
      n += sys_tick;
    end
    cmp(n, 30 / CR, "tick count");
  endtask : t_tick
  ////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    t_seq();
    t_branch(1'h0);
    t_branch(1'h1);
    t_jump();
    t_flush();
    t_stall();
    t_tick();
    wrap_up();
  end
  // scenarios need about 300 cycles; allow over fifteen times that
  initial begin
    #20000;
    fails++;
    wrap_up();
  end
endmodule : ifp_top_tb
`default_nettype wire
